/* core/isp_pin_sync.sv */
`timescale 1ns/1ps
module isp_pin_sync
  import isp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic lvl_q;
  logic lvl_d;

  always_comb
  begin
    sh_d = {sh_q[1:0], pin};
    lvl_d = lvl_q;
    if (sh_q[2] == sh_q[1])
      lvl_d = sh_q[2];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_q <= SYNC_RESET;
      lvl_q <= 1'b0;
    end
    else
    begin
      sh_q <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
  assign rise = lvl_d & ~lvl_q;
  assign fall = ~lvl_d & lvl_q;
endmodule : isp_pin_sync

/* core/isp_pkg.sv */
package isp_pkg;
  // ----------------------------------------------------------------
  // Instruction opcodes (first byte of a frame; the B2 values are second bytes)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE_ERASE = 8'hac;
  localparam logic [7:0] OP_ENABLE_B2 = 8'h53;
  localparam logic [7:0] OP_ERASE_B2 = 8'h80;
  localparam logic [7:0] OP_POLL = 8'hf0;
  localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
  localparam logic [7:0] OP_LOAD_HIGH = 8'h48;
  localparam logic [7:0] OP_LOAD_LOW = 8'h40;
  localparam logic [7:0] OP_READ_HIGH = 8'h28;
  localparam logic [7:0] OP_READ_LOW = 8'h20;
  localparam logic [7:0] OP_READ_EE = 8'ha0;
  localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
  localparam logic [7:0] OP_WRITE_EE = 8'hc0;
  // ----------------------------------------------------------------
  // Geometry and values
  // ----------------------------------------------------------------
  localparam int FLASH_AW = 8;
  localparam int PAGE_AW = 7;
  localparam int EE_AW = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] EXT_ADDR_RESET = 8'h00;
  localparam int FRAME_BITS = 32;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam real FLASH_WAIT_MS = 4.5;
  localparam real EEPROM_WAIT_MS = 9.0;
  localparam real ERASE_WAIT_MS = 9.0;
  localparam int FLASH_WAIT_CYC = int'(FLASH_WAIT_MS * 1000.0 * CLK_MHZ);
  localparam int EEPROM_WAIT_CYC = int'(EEPROM_WAIT_MS * 1000.0 * CLK_MHZ);
  localparam int ERASE_WAIT_CYC = int'(ERASE_WAIT_MS * 1000.0 * CLK_MHZ);
  localparam logic [2:0] SYNC_RESET = 3'b000;
endpackage : isp_pkg

/* core/isp_port.sv */
`timescale 1ns/1ps
module isp_port
  import isp_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_pin_n,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  output logic prog_mode,
  output logic busy_poll_flag
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_rise, sck_fall;
  logic rst_lvl, sdi_lvl;

  isp_pin_sync u_sck (.clk(clk), .arst_n(arst_n), .pin(sck),
    .level(), .rise(sck_rise), .fall(sck_fall));
  isp_pin_sync u_rst (.clk(clk), .arst_n(arst_n), .pin(reset_pin_n),
    .level(rst_lvl), .rise(), .fall());
  isp_pin_sync u_sdi (.clk(clk), .arst_n(arst_n), .pin(sdi),
    .level(sdi_lvl), .rise(), .fall());

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] flash_q [2**FLASH_AW];
  logic [7:0] ee_q [2**EE_AW];
  logic [7:0] page_q [2**(PAGE_AW+1)];

  typedef enum {ST_IDLE, ST_FLASH, ST_EE, ST_ERASE} busy_e;
  busy_e st_q, st_d;

  logic [31:0] frame_q, frame_d;
  logic [4:0] bit_q, bit_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] ext_q, ext_d;
  logic en_q, en_d;
  logic [31:0] wait_q, wait_d;
  logic [7:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [31:0] shifted;
  logic frame_done;

  // Model holds a single page, so upper word address bits alias
  function automatic logic [FLASH_AW-1:0] flash_index(
    input logic [7:0] lo, input logic high_b);
    flash_index = {lo[PAGE_AW-1:0], high_b};
  endfunction : flash_index

  // ----------------------------------------------------------------
  // Link and command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    frame_d = frame_q;
    bit_d = bit_q;
    tx_d = tx_q;
    ext_d = ext_q;
    en_d = en_q;
    st_d = st_q;
    wait_d = wait_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    shifted = {frame_q[30:0], sdi_lvl};
    frame_done = 1'b0;
    if (st_q != ST_IDLE)
    begin
      if (wait_q <= 32'd1)
        st_d = ST_IDLE;
      else
        wait_d = wait_q - 32'd1;
    end
    if (rst_lvl)
    begin
      // Leaving programming drops the enable and the frame position
      en_d = 1'b0;
      bit_d = 5'd0;
      tx_d = 8'h00;
    end
    else if (sck_rise)
    begin
      frame_d = shifted;
      bit_d = bit_q + 5'd1;
      if (bit_q == 5'd31)
        frame_done = 1'b1;
      if (bit_q == 5'd15)
      begin
        // Echo of byte two for enable; poll and reads load the answer
        tx_d = shifted[7:0];
        if (shifted[15:8] == OP_POLL)
          tx_d = {7'd0, st_q != ST_IDLE};
      end
      if (bit_q == 5'd23)
      begin
        tx_d = 8'h00;
        unique case (shifted[23:16])
          OP_READ_LOW:
            tx_d = flash_q[flash_index(shifted[7:0], 1'b0)];
          OP_READ_HIGH:
            tx_d = flash_q[flash_index(shifted[7:0], 1'b1)];
          OP_READ_EE: tx_d = ee_q[shifted[EE_AW-1:0]];
          OP_POLL: tx_d = {7'd0, st_q != ST_IDLE};
          default: tx_d = 8'h00;
        endcase
      end
      if (frame_done)
      begin
        if (shifted[31:24] == OP_ENABLE_ERASE &&
            shifted[23:16] == OP_ENABLE_B2)
          en_d = 1'b1;
        if (en_q && st_q == ST_IDLE)
        begin
          unique case (shifted[31:24])
            OP_LOAD_EXT: ext_d = shifted[15:8];
            OP_WRITE_PAGE:
            begin
              st_d = ST_FLASH;
              wait_d = 32'(FLASH_WAIT_CYC);
            end
            OP_WRITE_EE:
            begin
              st_d = ST_EE;
              wait_d = 32'(EEPROM_WAIT_CYC);
              waddr_d = shifted[15:8];
              wdata_d = shifted[7:0];
            end
            OP_ENABLE_ERASE:
              if (shifted[23:16] == OP_ERASE_B2)
              begin
                st_d = ST_ERASE;
                wait_d = 32'(ERASE_WAIT_CYC);
              end
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_q <= 32'h0000_0000;
      bit_q <= 5'd0;
      tx_q <= 8'h00;
      ext_q <= EXT_ADDR_RESET;
      en_q <= 1'b0;
      st_q <= ST_IDLE;
      wait_q <= 32'h0000_0000;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
    end
    else
    begin
      frame_q <= frame_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      ext_q <= ext_d;
      en_q <= en_d;
      st_q <= st_d;
      wait_q <= wait_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Memory arrays; only flip-flops, small model of the arrays
  // ----------------------------------------------------------------
  logic load_hit;
  assign load_hit = sck_rise && bit_q == 5'd31 && !rst_lvl && en_q &&
    st_q == ST_IDLE;

  always_ff @(posedge clk)
  begin
    // Loading the page buffer; low and high byte share a word slot
    if (load_hit && frame_q[30:23] == OP_LOAD_LOW)
      page_q[flash_index(frame_q[14:7], 1'b0)] <=
        {frame_q[6:0], sdi_lvl};
    if (load_hit && frame_q[30:23] == OP_LOAD_HIGH)
      page_q[flash_index(frame_q[14:7], 1'b1)] <=
        {frame_q[6:0], sdi_lvl};
    // Page and EEPROM commit at the first busy cycle; erase rewrites the arrays on every erase cycle
    if (st_q == ST_FLASH && wait_q == 32'(FLASH_WAIT_CYC))
      for (int i = 0; i < 2**FLASH_AW; i++)
        flash_q[i] <= page_q[i];
    if (st_q == ST_EE && wait_q == 32'(EEPROM_WAIT_CYC))
      ee_q[waddr_q[EE_AW-1:0]] <= wdata_q;
    if (st_q == ST_ERASE)
    begin
      for (int i = 0; i < 2**FLASH_AW; i++)
        flash_q[i] <= ERASED_BYTE;
      for (int i = 0; i < 2**EE_AW; i++)
        ee_q[i] <= ERASED_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Serial output; driven whenever the reset pin is low, changed on falls
  // ----------------------------------------------------------------
  logic sdo_q, sdo_d;
  always_comb
  begin
    sdo_d = sdo_q;
    if (rst_lvl)
      sdo_d = 1'b0;
    else if (sck_fall && bit_q >= 5'd16)
      sdo_d = tx_q[3'(5'd23 - bit_q)];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sdo_q <= 1'b0;
    else
      sdo_q <= sdo_d;
  end

  assign sdo = sdo_q;
  assign sdo_oe_n = rst_lvl;
  assign prog_mode = en_q;
  assign busy_poll_flag = st_q != ST_IDLE;

  AST_ECHO_EXT: assert property (
    @(posedge clk) disable iff (!arst_n)
    frame_done && en_q && st_q == ST_IDLE && frame_q[30:23] == OP_LOAD_EXT
    |=> ext_q == $past(frame_q[14:7]))
    else $error("extended address not taken");
  AST_NO_PROG_RESET: assert property (
    @(posedge clk) disable iff (!arst_n)
    rst_lvl |=> !en_q)
    else $error("enable kept in reset");
  AST_BUSY_FLAG: assert property (
    @(posedge clk) disable iff (!arst_n)
    busy_poll_flag && wait_q > 32'd1 |=> busy_poll_flag)
    else $error("busy flag dropped early");
  AST_NEED_ENABLE: assert property (
    @(posedge clk) disable iff (!arst_n)
    !en_q && st_q == ST_IDLE |=> st_q == ST_IDLE)
    else $error("write started without enable");
  AST_SDO_ON_FALL: assert property (
    @(posedge clk) disable iff (!arst_n)
    !sck_fall && !rst_lvl |=> sdo == $past(sdo))
    else $error("serial output moved off a fall");
  AST_BIT_COUNT: assert property (
    @(posedge clk) disable iff (!arst_n)
    sck_rise && !rst_lvl |=> bit_q == $past(bit_q) + 5'd1)
    else $error("bit position not advanced");
  AST_ECHO_B2: assert property (
    @(posedge clk) disable iff (!arst_n)
    sck_rise && !rst_lvl && bit_q == 5'd15 && frame_q[14:7] != OP_POLL
    |=> tx_q == $past(shifted[7:0]))
    else $error("second byte not loaded for echo");
endmodule : isp_port

/* dv/isp_programmer.sv */
`timescale 1ns/1ps
module isp_programmer (
  input wire logic clk,
  output logic reset_pin_n,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  // ----------------------------------------------------------------
  // Pin state at power-up
  // ----------------------------------------------------------------
  // Reset and clock held low from time zero
  initial
  begin
    reset_pin_n = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Timing helpers
  // ----------------------------------------------------------------
  // Forty ns phases, eight core cycles, well above three
  task automatic half_period();
    repeat (8) @(negedge clk);
  endtask : half_period

  // Reset pulse far above two core cycles
  task automatic pin_pulse();
    @(negedge clk);
    reset_pin_n = 1'b1;
    repeat (8) @(negedge clk);
    reset_pin_n = 1'b0;
    // Stand-in for the power-up wait, which the port never times
    repeat (16) @(negedge clk);
  endtask : pin_pulse

  task automatic set_pin(input logic v);
    @(negedge clk);
    reset_pin_n = v;
  endtask : set_pin

  // ----------------------------------------------------------------
  // Frame transfer
  // ----------------------------------------------------------------
  // All 32 bits always sent, whatever comes back
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    // One idle edge so back-to-back frames never touch the line at once
    @(negedge clk);
    for (int i = 31; i >= 0; i--)
    begin
      sdi = tx[i];
      half_period();
      rx[i] = sdo;
      sck = 1'b1;
      half_period();
      sck = 1'b0;
    end
    // Data line is meaningless between frames, so never leave it stable
    sdi = ~sdi;
  endtask : xfer
endmodule : isp_programmer

/* dv/serial_isp_programming_port_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module serial_isp_programming_port_tb;
  import isp_pkg::*;
  localparam int LIMIT = 40000;
  logic clk;
  logic arst_n;
  logic reset_pin_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic prog_mode;
  logic busy_poll_flag;
  logic [31:0] rx;
  logic [7:0] r8;
  logic [7:0] pg [256];
  logic [6:0] wa [4];
  int errors;
  int n_checks;
  int cyc;
  int seed_v;

  isp_port isp_port_i (
    .clk(clk),
    .arst_n(arst_n),
    .reset_pin_n(reset_pin_n),
    .sck(sck),
    .sdi(sdi),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .prog_mode(prog_mode),
    .busy_poll_flag(busy_poll_flag)
  );

  isp_programmer isp_programmer_i (
    .clk(clk),
    .reset_pin_n(reset_pin_n),
    .sck(sck),
    .sdi(sdi),
    .sdo(sdo)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] frame(input logic [7:0] b1,
    input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
    return {b1, b2, b3, b4};
  endfunction : frame

  // Byte slot of a word in the expected page image
  function automatic logic [7:0] slot(input logic [6:0] a, input logic hi);
    return {a, hi};
  endfunction : slot

  task automatic settle();
    repeat (16) @(negedge clk);
  endtask : settle

  // Block reset mid-run ends the busy time; arrays keep their contents
  task automatic restart();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    settle();
    `CHK(busy_poll_flag, 1'b0)
    `CHK(prog_mode, 1'b0)
    isp_programmer_i.xfer(frame(OP_ENABLE_ERASE, OP_ENABLE_B2, 8'h00,
      8'h00), rx);
    `CHK(rx[15:8], OP_ENABLE_B2)
  endtask : restart

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      errors++;
      $display("ERROR %0t: run did not finish", $time);
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    seed_v = $urandom(32'h16b1);
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    isp_programmer_i.pin_pulse();
    `CHK(sdo_oe_n, 1'b0)
    // Erase before enable must be ignored
    isp_programmer_i.xfer(frame(OP_ENABLE_ERASE, OP_ERASE_B2, 8'h00,
      8'h00), rx);
    settle();
    `CHK(busy_poll_flag, 1'b0)
    `CHK(prog_mode, 1'b0)
    isp_programmer_i.xfer(frame(OP_ENABLE_ERASE, OP_ENABLE_B2, 8'h00,
      8'h00), rx);
    settle();
    `CHK(rx[15:8], OP_ENABLE_B2)
    `CHK(prog_mode, 1'b1)
    // Page loads, low byte first, top word as a corner, polls between
    for (int k = 0; k < 4; k++)
    begin
      wa[k] = (k == 0) ? 7'h7f : 7'($urandom);
      pg[slot(wa[k], 1'b0)] = 8'($urandom);
      pg[slot(wa[k], 1'b1)] = 8'($urandom);
      isp_programmer_i.xfer(frame(OP_LOAD_EXT, 8'h00, 8'($urandom),
        8'h00), rx);
      isp_programmer_i.xfer(frame(OP_LOAD_LOW, 8'h00, {1'b0, wa[k]},
        pg[slot(wa[k], 1'b0)]), rx);
      isp_programmer_i.xfer(frame(OP_LOAD_HIGH, 8'h00, {1'b0, wa[k]},
        pg[slot(wa[k], 1'b1)]), rx);
      isp_programmer_i.xfer(frame(OP_POLL, 8'($urandom), 8'($urandom),
        8'h00), rx);
      `CHK(rx[7:0], 8'h00)
    end
    // Page commit; the link stays quiet until the block restarts
    isp_programmer_i.xfer(frame(OP_WRITE_PAGE, 8'h00, 8'h00, 8'h00), rx);
    settle();
    `CHK(busy_poll_flag, 1'b1)
    restart();
    for (int k = 0; k < 8; k++)
    begin
      isp_programmer_i.xfer(frame(k[0] ? OP_READ_HIGH : OP_READ_LOW,
        8'h00, {1'b0, wa[k/2]}, 8'h00), rx);
      `CHK(rx[7:0], pg[slot(wa[k/2], k[0])])
    end
    // Boundary address of the EEPROM, then busy must show
    r8 = 8'($urandom);
    isp_programmer_i.xfer(frame(OP_WRITE_EE, 8'h00, 8'h3f, r8), rx);
    settle();
    `CHK(busy_poll_flag, 1'b1)
    isp_programmer_i.xfer(frame(OP_POLL, 8'h00, 8'h00, 8'h00), rx);
    `CHK(rx[0], 1'b1)
    restart();
    isp_programmer_i.xfer(frame(OP_READ_EE, 8'h00, 8'h3f, 8'h00), rx);
    `CHK(rx[7:0], r8)
    // Chip erase once enabled; one byte of each array reads back as all ones
    isp_programmer_i.xfer(frame(OP_ENABLE_ERASE, OP_ERASE_B2, 8'h00,
      8'h00), rx);
    settle();
    `CHK(busy_poll_flag, 1'b1)
    restart();
    isp_programmer_i.xfer(frame(OP_READ_HIGH, 8'h00, {1'b0, wa[0]},
      8'h00), rx);
    `CHK(rx[7:0], ERASED_BYTE)
    isp_programmer_i.xfer(frame(OP_READ_EE, 8'h00, 8'h3f, 8'h00), rx);
    `CHK(rx[7:0], ERASED_BYTE)
    // Releasing the reset pin ends the session
    isp_programmer_i.set_pin(1'b1);
    settle();
    `CHK(prog_mode, 1'b0)
    `CHK(sdo_oe_n, 1'b1)
    isp_programmer_i.xfer(frame(OP_ENABLE_ERASE, OP_ENABLE_B2, 8'h00,
      8'h00), rx);
    settle();
    `CHK(prog_mode, 1'b0)
    test_done();
  end
endmodule : serial_isp_programming_port_tb
